// ===== include/epss_map.svh
// register offsets, field positions, reset values and timing counts for the pwm steering block
`ifndef EPSS_MAP_SVH
`define EPSS_MAP_SVH

`define EPSS_OFF_TSEL_LO  8'h00
`define EPSS_OFF_TSEL_HI  8'h04
`define EPSS_OFF_SD_CTL   8'h08
`define EPSS_OFF_RST_DLY  8'h0c
`define EPSS_OFF_STEER    8'h10
`define EPSS_OFF_MODE     8'h14
`define EPSS_OFF_IRQ_ST   8'h18
`define EPSS_OFF_IRQ_CLR  8'h1c
`define EPSS_OFF_IRQ_EN   8'h20

`define EPSS_SD_FLAG_BIT  7
`define EPSS_RSEN_BIT     7
`define EPSS_SYNC_BIT     4

`define EPSS_RST_TSEL_LO  8'h00
`define EPSS_RST_TSEL_HI  2'h0
`define EPSS_RST_SD_CTL   8'h00
`define EPSS_RST_RST_DLY  8'h00
`define EPSS_RST_STEER    5'h01
`define EPSS_RST_MODE     8'h00

`define EPSS_TB_RESERVED  2'h3
`define EPSS_CLK_NS       5
`define EPSS_INST_NS      20
`define EPSS_INST_CYC     (`EPSS_INST_NS / `EPSS_CLK_NS)

`endif

// ===== include/epss_pkg.sv
// types shared by the pwm steering and shutdown block
package epss_pkg;

  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe;
  } epss_pin_t;

  typedef enum logic [1:0] {
    DLY_IDLE   = 2'b00,
    DLY_WAIT   = 2'b01,
    DLY_ACTIVE = 2'b10
  } epss_dly_state_t;

endpackage : epss_pkg

// ===== hw/epss_top.sv
// enhanced pwm time-base select, auto-shutdown, active-edge delay and output steering
// Operation
// - two-bit selector picks timer per channel
// - channel five selector, upper bits read zero
// - status bit seven shows shutdown state
// - three-bit source select of shutdown trigger
// - shutdown level for pins a and c
// - shutdown level for pins b and d
// - auto restart clears status when condition ends
// - without auto restart, software clears status
// - active edge delayed by instruction cycles
// - steering update on period or instruction
// - steering bits route waveform with polarity
// - steering only in single-output pwm mode
// - comparator sync delays shutdown to aux timer
// - low mode bits set pin polarity
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`include "epss_map.svh"

module epss_top
  import epss_pkg::*;
(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            nrst,
  // apb slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // timers and pwm datapath
  input  wire logic [2:0]      tmr_period,
  input  wire logic            aux_tick,
  input  wire logic            pwm_raw,
  output logic      [4:0]      chan_period,
  // shutdown sources (asynchronous pins)
  input  wire logic            cmp1_in,
  input  wire logic            cmp2_in,
  input  wire logic            ext_int_pin,
  // pins: index 0..3 is pwm_out_a..pwm_out_d
  input  epss_pin_t            port_pins,
  output epss_pin_t            pwm_out,
  // interrupt
  output logic                 irq
);

  logic [7:0]      tsel_lo_ff;
  logic [1:0]      tsel_hi_ff;
  logic            shutdown_event_flag_ff;
  logic [2:0]      shutdown_source_sel_ff;
  logic [1:0]      shutdown_level_ac_ff;
  logic [1:0]      shutdown_level_bd_ff;
  logic            auto_restart_en_ff;
  logic [6:0]      active_edge_delay_ff;
  logic [4:0]      steer_ff;
  logic [3:0]      steer_act_ff;
  logic [3:0]      channel_mode_sel_ff;
  logic [1:0]      output_config_sel_ff;
  logic [1:0]      comparator_sync_en_ff;
  logic [1:0]      irq_st_ff;
  logic [1:0]      irq_en_ff;
  logic [31:0]     prdata_ff;
  logic [4:0]      chan_period_ff;
  logic [1:0]      phase_ff;
  logic [2:0]      sync1_ff;
  logic [2:0]      sync2_ff;
  logic [1:0]      cmp_tmr_ff;
  logic            raw_q_ff;
  logic [6:0]      dly_cnt_ff;
  epss_dly_state_t dly_state_ff;
  epss_pin_t       pin_ff;
  logic            wr_en;
  logic            hit;
  logic            inst_tick;
  logic            c1_lvl;
  logic            c2_lvl;
  logic            trig;
  logic            steer_on;
  logic            pwm_dly;
  logic            raw_rise;
  logic            sd_sw_wr;
  logic [1:0]      irq_ev;
  logic [31:0]     nxt_prdata;
  epss_pin_t       nxt_pin;

  // ---------------- apb slave ----------------
  // zero wait states; read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = prdata_ff;

  always_comb begin
    hit        = 1'b1;
    nxt_prdata = 32'h0;
    unique case (paddr)
      `EPSS_OFF_TSEL_LO: nxt_prdata = {24'h0, tsel_lo_ff};
      `EPSS_OFF_TSEL_HI: nxt_prdata = {30'h0, tsel_hi_ff};
      `EPSS_OFF_SD_CTL:  nxt_prdata = {24'h0, shutdown_event_flag_ff, shutdown_source_sel_ff,
                                       shutdown_level_ac_ff, shutdown_level_bd_ff};
      `EPSS_OFF_RST_DLY: nxt_prdata = {24'h0, auto_restart_en_ff, active_edge_delay_ff};
      `EPSS_OFF_STEER:   nxt_prdata = {27'h0, steer_ff};
      `EPSS_OFF_MODE:    nxt_prdata = {24'h0, output_config_sel_ff, comparator_sync_en_ff,
                                       channel_mode_sel_ff};
      `EPSS_OFF_IRQ_ST:  nxt_prdata = {30'h0, irq_st_ff};
      `EPSS_OFF_IRQ_CLR: nxt_prdata = 32'h0;
      `EPSS_OFF_IRQ_EN:  nxt_prdata = {30'h0, irq_en_ff};
      default:           hit        = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata_ff <= 32'h0;
    end else if (psel & ~penable & ~pwrite) begin
      prdata_ff <= nxt_prdata;
    end
  end

  // configuration registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tsel_lo_ff            <= `EPSS_RST_TSEL_LO;
      tsel_hi_ff            <= `EPSS_RST_TSEL_HI;
      shutdown_source_sel_ff <= 3'(`EPSS_RST_SD_CTL >> 4);
      shutdown_level_ac_ff  <= 2'h0;
      shutdown_level_bd_ff  <= 2'h0;
      auto_restart_en_ff    <= 1'(`EPSS_RST_RST_DLY >> 7);
      active_edge_delay_ff  <= 7'h00;
      steer_ff              <= `EPSS_RST_STEER;
      channel_mode_sel_ff   <= 4'h0;
      comparator_sync_en_ff <= 2'h0;
      output_config_sel_ff  <= 2'h0;
      irq_en_ff             <= 2'h0;
    end else if (wr_en) begin
      unique case (paddr)
        `EPSS_OFF_TSEL_LO: tsel_lo_ff <= pwdata[7:0];
        `EPSS_OFF_TSEL_HI: tsel_hi_ff <= pwdata[1:0];
        `EPSS_OFF_SD_CTL: begin
          shutdown_source_sel_ff <= pwdata[6:4];
          shutdown_level_ac_ff   <= pwdata[3:2];
          shutdown_level_bd_ff   <= pwdata[1:0];
        end
        `EPSS_OFF_RST_DLY: begin
          auto_restart_en_ff   <= pwdata[`EPSS_RSEN_BIT];
          active_edge_delay_ff <= pwdata[6:0];
        end
        `EPSS_OFF_STEER: steer_ff <= pwdata[4:0];
        `EPSS_OFF_MODE: begin
          output_config_sel_ff  <= pwdata[7:6];
          comparator_sync_en_ff <= pwdata[5:4];
          channel_mode_sel_ff   <= pwdata[3:0];
        end
        `EPSS_OFF_IRQ_EN: irq_en_ff <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // ---------------- time base selection ----------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chan_period_ff <= 5'h00;
    end else begin
      for (int i = 0; i < 4; i++) begin
        chan_period_ff[i] <= (tsel_lo_ff[2*i +: 2] != `EPSS_TB_RESERVED) &&
                             tmr_period[tsel_lo_ff[2*i +: 2]];
      end
      chan_period_ff[4] <= (tsel_hi_ff != `EPSS_TB_RESERVED) && tmr_period[tsel_hi_ff];
    end
  end
  assign chan_period = chan_period_ff;

  // instruction cycle: four clocks
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_ff <= 2'h0;
    end else begin
      phase_ff <= phase_ff + 2'h1;
    end
  end
  assign inst_tick = (phase_ff == 2'(`EPSS_INST_CYC - 1));

  // ---------------- shutdown sources ----------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_ff <= 3'h4;
      sync2_ff <= 3'h4;
    end else begin
      sync1_ff <= {ext_int_pin, cmp2_in, cmp1_in};
      sync2_ff <= sync1_ff;
    end
  end

  // comparator levels only advance on the aux timer tick when sync is enabled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmp_tmr_ff <= 2'h0;
    end else if (aux_tick) begin
      cmp_tmr_ff <= sync2_ff[1:0];
    end
  end
  assign c1_lvl = comparator_sync_en_ff[0] ? cmp_tmr_ff[0] : sync2_ff[0];
  assign c2_lvl = comparator_sync_en_ff[1] ? cmp_tmr_ff[1] : sync2_ff[1];
  // bit2 adds the low interrupt pin, bit0 comparator one, bit1 comparator two
  assign trig = (shutdown_source_sel_ff[2] & ~sync2_ff[2]) |
                (shutdown_source_sel_ff[0] & c1_lvl) |
                (shutdown_source_sel_ff[1] & c2_lvl);

  // ---------------- shutdown status ----------------
  assign sd_sw_wr = wr_en && (paddr == `EPSS_OFF_SD_CTL);
  // a live trigger wins over a software clear so no event is lost
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shutdown_event_flag_ff <= 1'b0;
    end else if (trig) begin
      shutdown_event_flag_ff <= 1'b1;
    end else if (sd_sw_wr) begin
      shutdown_event_flag_ff <= pwdata[`EPSS_SD_FLAG_BIT];
    end else if (auto_restart_en_ff) begin
      shutdown_event_flag_ff <= 1'b0;
    end
  end

  // ---------------- interrupts ----------------
  // bit0: shutdown entered, bit1: shutdown released
  assign irq_ev = {shutdown_event_flag_ff & ~trig & (auto_restart_en_ff | sd_sw_wr) &
                   ~(sd_sw_wr & pwdata[`EPSS_SD_FLAG_BIT]),
                   trig & ~shutdown_event_flag_ff};
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_st_ff <= 2'h0;
    end else if (wr_en && (paddr == `EPSS_OFF_IRQ_CLR)) begin
      irq_st_ff <= (irq_st_ff & ~pwdata[1:0]) | irq_ev;
    end else begin
      irq_st_ff <= irq_st_ff | irq_ev;
    end
  end
  assign irq = |(irq_st_ff & irq_en_ff);

  // ---------------- active-edge delay ----------------
  assign raw_rise = pwm_raw & ~raw_q_ff;
  // the first instruction cycle of the wait may be partial, the edge stays on the tick grid
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      raw_q_ff     <= 1'b0;
      dly_cnt_ff   <= 7'h00;
      dly_state_ff <= DLY_IDLE;
    end else begin
      raw_q_ff <= pwm_raw;
      unique case (dly_state_ff)
        DLY_IDLE: begin
          if (raw_rise) begin
            dly_cnt_ff   <= active_edge_delay_ff;
            dly_state_ff <= (active_edge_delay_ff == 7'h00) ? DLY_ACTIVE : DLY_WAIT;
          end
        end
        DLY_WAIT: begin
          if (!pwm_raw) begin
            dly_state_ff <= DLY_IDLE;
          end else if (inst_tick) begin
            dly_cnt_ff <= dly_cnt_ff - 7'h01;
            if (dly_cnt_ff == 7'h01) begin
              dly_state_ff <= DLY_ACTIVE;
            end
          end
        end
        DLY_ACTIVE: begin
          if (!pwm_raw) begin
            dly_state_ff <= DLY_IDLE;
          end
        end
        default: dly_state_ff <= DLY_IDLE;
      endcase
    end
  end
  assign pwm_dly = (dly_state_ff == DLY_ACTIVE);

  // ---------------- steering ----------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      steer_act_ff <= 4'(`EPSS_RST_STEER & 5'h0f);
    end else if (steer_ff[`EPSS_SYNC_BIT] ? chan_period_ff[0] : inst_tick) begin
      steer_act_ff <= steer_ff[3:0];
    end
  end
  assign steer_on = (channel_mode_sel_ff[3:2] == 2'h3) && (output_config_sel_ff == 2'h0);

  always_comb begin
    nxt_pin = port_pins;
    for (int i = 0; i < 4; i++) begin
      if (steer_on && steer_act_ff[i]) begin
        if (shutdown_event_flag_ff) begin
          // even pins are a and c, odd pins are b and d
          if (i % 2 == 0) begin
            nxt_pin.o[i]  = shutdown_level_ac_ff[0];
            nxt_pin.oe[i] = ~shutdown_level_ac_ff[1];
          end else begin
            nxt_pin.o[i]  = shutdown_level_bd_ff[0];
            nxt_pin.oe[i] = ~shutdown_level_bd_ff[1];
          end
        end else begin
          nxt_pin.o[i]  = pwm_dly ^ channel_mode_sel_ff[(i % 2 == 0) ? 1 : 0];
          nxt_pin.oe[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_ff <= '0;
    end else begin
      pin_ff <= nxt_pin;
    end
  end
  assign pwm_out = pin_ff;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // eight held cycles span at most two ticks, far short of a five-tick delay
  sequence s_rise_dly5;
    raw_rise && (dly_state_ff == DLY_IDLE) && (active_edge_delay_ff == 7'h05);
  endsequence
  sequence s_held8;
    pwm_raw [*8];
  endsequence

  chk_tsel_reserved: assert property (
    (tsel_lo_ff[1:0] == 2'h3) |=> !chan_period_ff[0]) else $error("reserved timer selected");
  chk_hi_upper_zero: assert property (
    psel && !penable && !pwrite && (paddr == `EPSS_OFF_TSEL_HI) |=> (prdata[31:2] == 30'h0))
    else $error("upper select bits not zero");
  chk_shutdown_sets: assert property (
    trig |=> shutdown_event_flag_ff) else $error("trigger did not set shutdown");
  chk_auto_restart: assert property (
    shutdown_event_flag_ff && auto_restart_en_ff && !trig && !sd_sw_wr |=> !shutdown_event_flag_ff)
    else $error("auto restart did not clear status");
  chk_manual_hold: assert property (
    shutdown_event_flag_ff && !auto_restart_en_ff && !sd_sw_wr |=> shutdown_event_flag_ff)
    else $error("status cleared without software");
  chk_sw_clear: assert property (
    shutdown_event_flag_ff && sd_sw_wr && !pwdata[`EPSS_SD_FLAG_BIT] && !trig
    |=> !shutdown_event_flag_ff) else $error("software clear ignored");
  chk_enter_irq: assert property (
    trig && !shutdown_event_flag_ff |=> irq_st_ff[0]) else $error("shutdown entry not flagged");
  chk_pin_ac_state: assert property (
    steer_on && steer_act_ff[0] && shutdown_event_flag_ff && (shutdown_level_ac_ff == 2'h1)
    |=> pwm_out.oe[0] && pwm_out.o[0]) else $error("pin a not at shutdown level");
  chk_pin_bd_float: assert property (
    steer_on && steer_act_ff[1] && shutdown_event_flag_ff && shutdown_level_bd_ff[1]
    |=> !pwm_out.oe[1]) else $error("pin b not released in shutdown");
  chk_edge_delay: assert property (
    s_rise_dly5 ##1 s_held8 |-> !pwm_dly) else $error("active edge came too early");
  chk_steer_sync: assert property (
    steer_ff[`EPSS_SYNC_BIT] && !chan_period_ff[0] |=> $stable(steer_act_ff))
    else $error("steering changed off period");
  chk_port_passthru: assert property (
    !steer_on |=> (pwm_out == $past(port_pins))) else $error("pins not under port control");
  chk_polarity_ac: assert property (
    steer_on && steer_act_ff[2] && !shutdown_event_flag_ff
    |=> pwm_out.o[2] == ($past(pwm_dly) ^ $past(channel_mode_sel_ff[1])))
    else $error("pin c polarity wrong");
  chk_cmp_sync: assert property (
    !aux_tick |=> $stable(cmp_tmr_ff)) else $error("comparator resampled off tick");

endmodule : epss_top

// ===== test/epss_far_model.sv
// far-side model: period timers, auxiliary tick and the shutdown sources
`timescale 1ns/100ps

module epss_far_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // commands from the bench
  input  wire logic       run,
  input  wire logic [2:0] trip,
  // toward the block
  output logic      [2:0] tmr_period,
  output logic            aux_tick,
  output logic            cmp1_in,
  output logic            cmp2_in,
  output logic            ext_int_pin
);
  logic [7:0] cnt_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 8'h00;
    end else if (run) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // timers differ in period and phase so a wrong selection shows
  assign tmr_period[0] = run && (cnt_ff[2:0] == 3'h7);
  assign tmr_period[1] = run && (cnt_ff[3:0] == 4'h5);
  assign tmr_period[2] = run && (cnt_ff[4:0] == 5'h09);
  assign aux_tick      = run && (cnt_ff[2:0] == 3'h3);
  // comparators trip high, the interrupt pin trips low
  assign cmp1_in       = trip[0];
  assign cmp2_in       = trip[1];
  assign ext_int_pin   = ~trip[2];
endmodule : epss_far_model

// ===== test/tb_top.sv
// self-checking bench for the pwm steering and shutdown block
`timescale 1ns/100ps

module tb_top
  import epss_pkg::*;
;
  typedef struct {
    logic [7:0] a;
    logic       wr;
    logic [7:0] d;
    logic [7:0] e;
  } epss_row_t;

  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic        aux_tick, pwm_raw, cmp1_in, cmp2_in, ext_int_pin, irq, run, mon_on;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [2:0]  tmr_period, prev_tmr, trip;
  logic [4:0]  chan_period;
  epss_pin_t   port_pins, pwm_out;
  int          fail_count, total_checks, n;
  epss_row_t   rows [13];

  epss_top i_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tmr_period(tmr_period), .aux_tick(aux_tick), .pwm_raw(pwm_raw),
    .chan_period(chan_period), .cmp1_in(cmp1_in), .cmp2_in(cmp2_in),
    .ext_int_pin(ext_int_pin), .port_pins(port_pins), .pwm_out(pwm_out), .irq(irq));

  epss_far_model i_far (.clk(clk), .nrst(nrst), .run(run), .trip(trip),
    .tmr_period(tmr_period), .aux_tick(aux_tick), .cmp1_in(cmp1_in),
    .cmp2_in(cmp2_in), .ext_int_pin(ext_int_pin));

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // one idle edge first, so a release and the next setup never share a time step
  task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    apb_xfer(1'b1, a, d);
  endtask : reg_wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
    apb_xfer(1'b0, a, 8'h00);
    check(rdv, e, what);
  endtask : rd_chk

  task automatic wait_o(input int i, input logic v, input int lim);
    n = 0;
    while (pwm_out.o[i] !== v && n < lim) begin
      n++;
      @(posedge clk);
    end
  endtask : wait_o

  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done

  always @(posedge clk) begin
    prev_tmr <= tmr_period;
    if (mon_on) begin
      check({27'h0, chan_period}, {27'h0, prev_tmr[2], prev_tmr[0], prev_tmr[2],
        prev_tmr[1], prev_tmr[0]}, "chan period");
    end
  end

  // the whole sequence needs about a thousand cycles
  initial begin
    #50000;
    fail_count++;
    $display("watchdog expired");
    tally_and_finish();
  end

  initial begin
    nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; pwm_raw = 1'b0; run = 1'b0; trip = 3'b000; mon_on = 1'b0;
    port_pins = '{o: 4'h0, oe: 4'h0};
    rows = '{'{8'h00, 0, 0, 8'h00}, '{8'h04, 0, 0, 8'h00}, '{8'h08, 0, 0, 8'h00},
      '{8'h0c, 0, 0, 8'h00}, '{8'h10, 0, 0, 8'h01}, '{8'h14, 0, 0, 8'h00},
      '{8'h18, 0, 0, 8'h00}, '{8'h00, 1, 8'h24, 8'h24}, '{8'h04, 1, 8'hfe, 8'h02},
      '{8'h0c, 1, 8'h7f, 8'h7f}, '{8'h10, 1, 8'hff, 8'h1f}, '{8'h14, 1, 8'h0c, 8'h0c},
      '{8'h18, 1, 8'hff, 8'h00}};
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) reg_wr(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, {24'h0, rows[i].e}, "register");
    end
    reg_wr(8'h0c, 8'h00);
    apb_xfer(1'b1, 8'h24, 8'h5a);
    check({31'h0, err}, 32'h1, "unmapped write");
    apb_xfer(1'b0, 8'h28, 8'h00);
    check({rdv[30:0], err}, 32'h1, "unmapped read");
    run <= 1'b1;
    mon_on <= 1'b1;
    repeat (64) @(posedge clk);
    mon_on <= 1'b0;
    reg_wr(8'h00, 8'hff);
    @(posedge clk);
    repeat (16) begin
      @(posedge clk);
      check({27'h0, chan_period}, {27'h0, prev_tmr[2], 4'h0}, "reserved");
    end
    reg_wr(8'h00, 8'h24);
    done("registers");
    reg_wr(8'h10, 8'h0f);
    port_pins <= '{o: 4'hf, oe: 4'h5};
    pwm_raw <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      reg_wr(8'h14, 8'h0c | 8'(m));
      repeat (6) @(posedge clk);
      check({24'h0, pwm_out}, {24'h0, ~m[0], ~m[1], ~m[0], ~m[1], 4'hf}, "pol");
    end
    reg_wr(8'h10, 8'h05);
    repeat (6) @(posedge clk);
    check({24'h0, pwm_out}, 32'ha5, "port pins");
    for (int j = 0; j < 2; j++) begin
      reg_wr(8'h14, j ? 8'h0b : 8'h4f);
      repeat (6) @(posedge clk);
      check({24'h0, pwm_out}, 32'hf5, "no steering");
    end
    reg_wr(8'h14, 8'h0c);
    done("steering");
    reg_wr(8'h10, 8'h01);
    pwm_raw <= 1'b0;
    reg_wr(8'h0c, 8'h05);
    repeat (4) @(posedge clk);
    pwm_raw <= 1'b1;
    @(posedge clk);
    wait_o(0, 1'b1, 60);
    check(32'(n >= 16 && n <= 24), 32'h1, "delay");
    pwm_raw <= 1'b0;
    @(posedge clk);
    wait_o(0, 1'b0, 4);
    check(32'(n < 4), 32'h1, "fall");
    reg_wr(8'h0c, 8'h00);
    done("delay");
    port_pins <= '{o: 4'h0, oe: 4'hf};
    pwm_raw <= 1'b1;
    run <= 1'b0;
    reg_wr(8'h10, 8'h11);
    repeat (8) @(posedge clk);
    reg_wr(8'h10, 8'h12);
    repeat (10) @(posedge clk);
    check({30'h0, pwm_out.o[1:0]}, 32'h1, "sync held");
    run <= 1'b1;
    repeat (12) @(posedge clk);
    check({30'h0, pwm_out.o[1:0]}, 32'h2, "sync applied");
    done("sync");
    pwm_raw <= 1'b0;
    reg_wr(8'h10, 8'h01);
    reg_wr(8'h20, 8'h01);
    reg_wr(8'h08, 8'h14);
    trip <= 3'b001;
    @(posedge clk);
    wait_o(0, 1'b1, 12);
    check({30'h0, n < 12, irq}, 32'h3, "shutdown level");
    trip <= 3'b000;
    repeat (10) @(posedge clk);
    rd_chk(8'h08, 32'h94, "flag held");
    check({31'h0, pwm_out.o[0]}, 32'h1, "still shut");
    trip <= 3'b001;
    repeat (6) @(posedge clk);
    reg_wr(8'h08, 8'h14);
    rd_chk(8'h08, 32'h94, "clear lost");
    trip <= 3'b000;
    repeat (6) @(posedge clk);
    reg_wr(8'h08, 8'h14);
    rd_chk(8'h08, 32'h14, "clear");
    wait_o(0, 1'b0, 6);
    check(32'(n < 6), 32'h1, "restart");
    reg_wr(8'h1c, 8'h03);
    @(posedge clk);
    check({31'h0, irq}, 32'h0, "irq clear");
    reg_wr(8'h10, 8'h03);
    reg_wr(8'h20, 8'h00);
    reg_wr(8'h0c, 8'h80);
    reg_wr(8'h08, 8'h49);
    trip <= 3'b100;
    repeat (8) @(posedge clk);
    check({26'h0, pwm_out.oe, pwm_out.o[1], irq}, 32'h3a, "tri-state");
    rd_chk(8'h18, 32'h1, "irq status");
    trip <= 3'b000;
    repeat (8) @(posedge clk);
    rd_chk(8'h08, 32'h49, "auto restart");
    rd_chk(8'h18, 32'h3, "released");
    reg_wr(8'h1c, 8'h03);
    rd_chk(8'h18, 32'h0, "cleared");
    done("shutdown");
    for (int s = 0; s < 8; s++) begin
      for (int k = 0; k < 3; k++) begin
        reg_wr(8'h08, {1'b0, 3'(s), 4'h0});
        trip <= 3'(1 << k);
        repeat (8) @(posedge clk);
        rd_chk(8'h08, {24'h0, s[k], 3'(s), 4'h0}, "source");
        trip <= 3'b000;
        repeat (8) @(posedge clk);
      end
    end
    done("sources");
    run <= 1'b0;
    reg_wr(8'h14, 8'h1c);
    reg_wr(8'h08, 8'h10);
    trip <= 3'b001;
    repeat (12) @(posedge clk);
    rd_chk(8'h08, 32'h10, "sync hold");
    run <= 1'b1;
    repeat (12) @(posedge clk);
    rd_chk(8'h08, 32'h90, "sync trip");
    done("comparator sync");
    nrst <= 1'b0;
    trip <= 3'b000;
    @(posedge clk);
    check({23'h0, pwm_out, irq}, 32'h0, "in reset");
    nrst <= 1'b1;
    rd_chk(8'h08, 32'h0, "after reset");
    rd_chk(8'h10, 32'h1, "steer reset");
    done("reset");
    tally_and_finish();
  end
endmodule : tb_top
